// [logic/iox_consts.svh]
// Purpose: constants of the eight-bit serial I/O expander
// Assumes: 40 MHz system clock, two-wire bus up to 400 kHz
// Notes: command codes, address high part and filter length are local
// Contract
// [R1] After power-on every pin is an input with its weak pull-up on.
// [R2] One direction bit per pin, written by the host, sets each pin.
// [R3] Sampled levels sit in the input register, driven ones in the latch.
// [R4] A set polarity bit makes the input register report the complement.
// [R5] Direction, polarity, output and input registers are all readable.
// [R6] Power-on reset restores register defaults and idles the bus FSM.
// [R7] The alert asserts while an input pin differs from its capture.
// [R8] The alert is active low and open drain, only ever pulled low.
// [R9] Three strap inputs form the low part of the slave address.
// [R10] The slave works at bus clock rates up to 400 kHz.
// [R11] Reading the input register recaptures pins and clears the alert.
// [R12] A command byte after the address byte selects the register.
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH

// Command byte codes
`define IOX_CMD_IN 8'h00
`define IOX_CMD_OUT 8'h01
`define IOX_CMD_POL 8'h02
`define IOX_CMD_CFG 8'h03

// Fixed upper four address bits
`define IOX_ADDR_HI 4'h4

// Reset values: all inputs, latch high, no inversion
`define IOX_RST_CFG 8'hFF
`define IOX_RST_OUT 8'hFF
`define IOX_RST_POL 8'h00

// Bit count of one byte on the bus
`define IOX_BYTE_BITS 4'h8

// Cycles after reset release before straps and pins are valid
`define IOX_INIT_CYC 2'h2

// Timing: system clock, bus spike width, derived filter cycles
`define IOX_CLK_HZ 40000000
`define IOX_SPIKE_NS 50
`define IOX_FILT_CYC ((`IOX_SPIKE_NS * (`IOX_CLK_HZ / 1000000) + 999) / 1000)

`endif

// [logic/iox_pkg.sv]
// Purpose: shared types of the I/O expander
// Assumes: nothing beyond the constants header
// Notes: one-hot state codes written out
package iox_pkg;

	// Two-wire bus levels
	typedef struct packed {
		logic scl;
		logic sda;
	} iox_bus_t;

	// Host-writable register set
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] outp;
		logic [7:0] pol;
	} iox_regs_t;

	// Serial slave states
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_CMD = 9'h008,
		ST_CACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_RACK = 9'h100
	} iox_state_t;

endpackage

// [logic/iox_port.sv]
// Purpose: per-pin drivers of the expander port
// Assumes: cfg bit high means input
// Notes: all outputs are registered
`timescale 1ns/1ps
module iox_port #(
	parameter int unsigned PINS = 8
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic [PINS-1:0] cfg_i, // Direction, 1 is input
	input wire logic [PINS-1:0] outp_i, // Output latch
	output logic [PINS-1:0] pin_o, // Pin drive level
	output logic [PINS-1:0] pin_oe_o, // Pin driven when high
	output logic [PINS-1:0] pin_pullup_o // Weak pull-up enable
);
	genvar g;

	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			logic out_d;
			logic oe_d;
			logic pu_d;
			logic out_q;
			logic oe_q;
			logic pu_q;

			// Direction bit steers driver and pull-up
			always_comb begin
				out_d = outp_i[g];
				oe_d = ~cfg_i[g]; // [R2]
				pu_d = cfg_i[g];
			end

			// Reset leaves the pin an input with pull-up
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					out_q <= 1'b1;
					oe_q <= 1'b0; // [R1]
					pu_q <= 1'b1; // [R1]
				end else begin
					out_q <= out_d;
					oe_q <= oe_d;
					pu_q <= pu_d;
				end
			end

			assign pin_o[g] = out_q;
			assign pin_oe_o[g] = oe_q;
			assign pin_pullup_o[g] = pu_q;
		end
	endgenerate
endmodule // iox_port

// [logic/iox_sync.sv]
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: inputs are quasi-static relative to the clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module iox_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Async reset, active high
	input wire logic [WIDTH-1:0] d_i, // Asynchronous input
	output logic [WIDTH-1:0] q_o // Synchronised output
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Two flops; metastability settles in the first
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule // iox_sync

// [logic/iox_top.sv]
// Purpose: eight-bit serial I/O expander, slave on the two-wire bus
// Assumes: bus pins and straps are asynchronous to clk_i
// Notes: open-drain pins are level, enable pairs; enable low releases
`timescale 1ns/1ps
`include "iox_consts.svh"
module iox_top
	import iox_pkg::*;
#(
	parameter int unsigned FILT = `IOX_FILT_CYC
) (
	input wire logic clk_i, // System clock, 40 MHz
	input wire logic rst_i, // Power-on reset, async, active high
	input wire logic scl_i, // Bus clock from master
	input wire logic sda_i, // Bus data level
	output logic sda_o, // Bus data drive level
	output logic sda_oe_o, // Bus data pulled low when high
	input wire logic [7:0] pin_i, // Port pin levels
	output logic [7:0] pin_o, // Port drive levels
	output logic [7:0] pin_oe_o, // Port drivers on
	output logic [7:0] pin_pullup_o, // Port weak pull-ups on
	input wire logic addr_strap_bit0_i, // Address strap, bit 0
	input wire logic addr_strap_bit1_i, // Address strap, bit 1
	input wire logic addr_strap_bit2_i, // Address strap, bit 2
	output logic int_n_o, // Change alert drive level
	output logic int_n_oe_o // Change alert pulled low when high
);
	localparam int unsigned FW = (FILT < 2) ? 2 : $clog2(FILT + 1);

	// Synchronised inputs
	logic [12:0] sync_s;
	iox_bus_t raw_s;
	logic [7:0] pin_s;
	logic [2:0] strap_s;

	// Filtered bus and its previous sample
	iox_bus_t bus_d;
	iox_bus_t bus_q;
	iox_bus_t prev_q;
	logic [FW-1:0] fcnt_d;
	logic [FW-1:0] fcnt_q;

	// Bus events
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	// Slave state
	iox_state_t state_d;
	iox_state_t state_q;
	logic [3:0] bit_d;
	logic [3:0] bit_q;
	logic [7:0] sr_d;
	logic [7:0] sr_q;
	logic rw_d;
	logic rw_q;
	logic [7:0] ptr_d;
	logic [7:0] ptr_q;
	logic mack_d;
	logic mack_q;
	logic sda_oe_d;
	logic sda_oe_q;

	// Registers and captures
	iox_regs_t regs_d;
	iox_regs_t regs_q;
	logic [7:0] cap_d;
	logic [7:0] cap_q;
	logic [2:0] strap_d;
	logic [2:0] strap_q;
	logic [1:0] init_d;
	logic [1:0] init_q;
	logic int_oe_d;
	logic int_oe_q;

	// Helpers
	logic init_done;
	logic [7:0] rd_byte;
	logic rd_is_in;

	// Every asynchronous input passes two flops
	iox_sync #(
		.WIDTH(13)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i,
			pin_i, scl_i, sda_i}),
		.q_o(sync_s)
	);

	assign raw_s = sync_s[1:0];
	assign pin_s = sync_s[9:2];
	assign strap_s = sync_s[12:10];

	// Direction and latch drive the pins
	iox_port #(
		.PINS(8)
	) u_port (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cfg_i(regs_q.cfg),
		.outp_i(regs_q.outp),
		.pin_o(pin_o),
		.pin_oe_o(pin_oe_o),
		.pin_pullup_o(pin_pullup_o)
	);

	// Spike filter: a bus level change must hold FILT + 1 cycles.
	// At 40 MHz a 400 kHz bit still gives about fifty cycles a phase.
	// Held until start-up ends: cleared sync stages read as a low bus
	always_comb begin
		bus_d = bus_q;
		fcnt_d = '0;
		if (init_done && raw_s != bus_q) begin
			fcnt_d = fcnt_q + 1'b1;
			if (fcnt_q >= FW'(FILT)) begin // [R10]
				bus_d = raw_s;
				fcnt_d = '0;
			end
		end
	end

	// Edges and bus conditions from filtered levels
	assign scl_rise = ~prev_q.scl & bus_q.scl;
	assign scl_fall = prev_q.scl & ~bus_q.scl;
	assign start_ev = prev_q.scl & bus_q.scl & prev_q.sda & ~bus_q.sda;
	assign stop_ev = prev_q.scl & bus_q.scl & ~prev_q.sda & bus_q.sda;
	assign init_done = (init_q == 2'h3);

	// Read mux selected by the command pointer
	always_comb begin
		rd_is_in = 1'b0;
		case (ptr_q)
			`IOX_CMD_IN: begin
				rd_byte = pin_s ^ regs_q.pol; // [R4]
				rd_is_in = 1'b1;
			end
			`IOX_CMD_OUT: begin
				rd_byte = regs_q.outp; // [R5]
			end
			`IOX_CMD_POL: begin
				rd_byte = regs_q.pol; // [R5]
			end
			`IOX_CMD_CFG: begin
				rd_byte = regs_q.cfg; // [R5]
			end
			default: begin
				rd_byte = 8'hFF;
			end
		endcase
	end

	// Slave state machine and register writes
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		sr_d = sr_q;
		rw_d = rw_q;
		ptr_d = ptr_q;
		mack_d = mack_q;
		sda_oe_d = sda_oe_q;
		regs_d = regs_q;
		cap_d = cap_q;
		// Straps and first pin capture once the synchroniser is filled
		if (init_q == `IOX_INIT_CYC) begin
			cap_d = pin_s; // [R3]
		end
		// Shift in address, command and write bytes on the rising edge
		if ((state_q == ST_ADDR || state_q == ST_CMD ||
			state_q == ST_WDATA) && scl_rise &&
			bit_q != `IOX_BYTE_BITS) begin
			sr_d = {sr_q[6:0], bus_q.sda};
			bit_d = bit_q + 4'h1;
		end
		if (!init_done) begin
			state_d = ST_IDLE;
		end else if (stop_ev) begin
			state_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_ev) begin
			// Repeated start also lands here
			state_d = ST_ADDR;
			bit_d = 4'h0;
			sda_oe_d = 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sda_oe_d = 1'b0;
				end
				ST_ADDR: begin
					if (scl_fall && bit_q == `IOX_BYTE_BITS) begin
						bit_d = 4'h0;
						if (sr_q[7:1] == {`IOX_ADDR_HI, strap_q}) begin // [R9]
							rw_d = sr_q[0];
							sda_oe_d = 1'b1;
							state_d = ST_AACK;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							// Byte loads while the clock is low
							sr_d = rd_byte;
							sda_oe_d = ~rd_byte[7];
							if (rd_is_in) begin
								cap_d = pin_s; // [R11]
							end
							state_d = ST_RDATA;
						end else begin
							sda_oe_d = 1'b0;
							state_d = ST_CMD;
						end
					end
				end
				ST_CMD: begin
					if (scl_fall && bit_q == `IOX_BYTE_BITS) begin
						bit_d = 4'h0;
						// Unknown commands get no acknowledge
						if (sr_q <= `IOX_CMD_CFG) begin
							ptr_d = sr_q; // [R12]
							sda_oe_d = 1'b1;
							state_d = ST_CACK;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				ST_CACK, ST_WACK: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						state_d = ST_WDATA;
					end
				end
				ST_WDATA: begin
					if (scl_fall && bit_q == `IOX_BYTE_BITS) begin
						bit_d = 4'h0;
						sda_oe_d = 1'b1;
						state_d = ST_WACK;
						// Input register ignores writes but still acks
						case (ptr_q)
							`IOX_CMD_OUT: begin
								regs_d.outp = sr_q; // [R3]
							end
							`IOX_CMD_POL: begin
								regs_d.pol = sr_q; // [R4]
							end
							`IOX_CMD_CFG: begin
								regs_d.cfg = sr_q; // [R2]
							end
							default: begin
								regs_d = regs_q;
							end
						endcase
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						bit_d = bit_q + 4'h1;
					end
					if (scl_fall) begin
						if (bit_q == `IOX_BYTE_BITS) begin
							bit_d = 4'h0;
							sda_oe_d = 1'b0;
							state_d = ST_RACK;
						end else begin
							sr_d = {sr_q[6:0], 1'b0};
							sda_oe_d = ~sr_q[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_d = ~bus_q.sda;
					end
					if (scl_fall) begin
						if (mack_q) begin
							// Master asked for more: same register again
							sr_d = rd_byte;
							sda_oe_d = ~rd_byte[7];
							if (rd_is_in) begin
								cap_d = pin_s; // [R11]
							end
							state_d = ST_RDATA;
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					sda_oe_d = 1'b0;
				end
			endcase
		end
	end

	// Alert, strap capture and start-up counter
	always_comb begin
		init_d = init_done ? init_q : init_q + 2'h1;
		strap_d = (init_q == `IOX_INIT_CYC) ? strap_s : strap_q; // [R9]
		// Only input pins count; outputs never raise the alert
		int_oe_d = init_done &&
			(|((pin_s ^ cap_q) & regs_q.cfg)); // [R7]
	end

	// Bus filter and edge history
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_q <= '{scl: 1'b1, sda: 1'b1};
			prev_q <= '{scl: 1'b1, sda: 1'b1};
			fcnt_q <= '0;
		end else begin
			bus_q <= bus_d;
			prev_q <= bus_q;
			fcnt_q <= fcnt_d;
		end
	end

	// Slave and register state; reset idles the machine
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE; // [R6]
			bit_q <= 4'h0;
			sr_q <= 8'h00;
			rw_q <= 1'b0;
			ptr_q <= `IOX_CMD_IN;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			regs_q <= '{cfg: `IOX_RST_CFG, outp: `IOX_RST_OUT,
				pol: `IOX_RST_POL}; // [R6]
			cap_q <= 8'h00;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			sr_q <= sr_d;
			rw_q <= rw_d;
			ptr_q <= ptr_d;
			mack_q <= mack_d;
			sda_oe_q <= sda_oe_d;
			regs_q <= regs_d;
			cap_q <= cap_d;
		end
	end

	// Strap, start-up and alert flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_q <= 3'h0;
			init_q <= 2'h0;
			int_oe_q <= 1'b0;
		end else begin
			strap_q <= strap_d;
			init_q <= init_d;
			int_oe_q <= int_oe_d;
		end
	end

	// Open-drain pins only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_q;
	assign int_n_o = 1'b0; // [R8]
	assign int_n_oe_o = int_oe_q; // [R8]
endmodule // iox_top

// [tb/iox_chk.sv]
// Purpose: port checker of the I/O expander
// Assumes: scl_i idles high between frames
// Notes: bound to iox_top at the foot
`timescale 1ns/1ps
module iox_chk #(
	parameter int unsigned FILT = 2
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Async reset
	input wire logic scl_i, // Bus clock
	input wire logic sda_i, // Bus data wire
	input wire logic sda_o, // Data drive level
	input wire logic sda_oe_o, // Data pulled low
	input wire logic [7:0] pin_i, // Pin levels
	input wire logic [7:0] pin_o, // Pin drive
	input wire logic [7:0] pin_oe_o, // Pin enables
	input wire logic [7:0] pin_pullup_o, // Pull-ups
	input wire logic addr_strap_bit0_i, // Strap 0
	input wire logic addr_strap_bit1_i, // Strap 1
	input wire logic addr_strap_bit2_i, // Strap 2
	input wire logic int_n_o, // Alert level
	input wire logic int_n_oe_o // Alert pulled low
);
	logic [7:0] mask_q, mask_d;
	logic [3:0] stab_q, stab_d, fall_q, fall_d;
	logic scl_q, scl_d;
	// Ages of the last input change and last bus clock fall
	always_comb begin
		mask_d = pin_i & pin_pullup_o;
		scl_d = scl_i;
		stab_d = (mask_d != mask_q) ? 4'h0 : stab_q + {3'h0, stab_q != 4'hF};
		fall_d = (scl_q && !scl_i) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
	end
	// Ages saturate so long idles never wrap
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_q <= 8'h00;
			stab_q <= 4'h0;
			fall_q <= 4'hF;
			scl_q <= 1'b1;
		end else begin
			mask_q <= mask_d;
			stab_q <= stab_d;
			fall_q <= fall_d;
			scl_q <= scl_d;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_boot;
		$fell(rst_i) |-> pin_oe_o == 8'h00 && pin_pullup_o == 8'hFF && !int_n_oe_o;
	endproperty
	a_boot: assert property (p_boot) else $error("pins not idle after reset");
	property p_dir;
		pin_pullup_o == ~pin_oe_o;
	endproperty
	a_dir: assert property (p_dir) else $error("pull-up and drive overlap");
	property p_lvl;
		!int_n_o && !sda_o;
	endproperty
	a_lvl: assert property (p_lvl) else $error("open drain level high");
	property p_src;
		$rose(int_n_oe_o) |-> stab_q < 4'h8;
	endproperty
	a_src: assert property (p_src) else $error("alert without pin change");
	property p_fast;
		!int_n_oe_o && $stable(pin_pullup_o) && $changed(pin_i & pin_pullup_o)
			|-> ##[1:6] int_n_oe_o;
	endproperty
	a_fast: assert property (p_fast) else $error("alert missed");
	property p_wr;
		$changed(pin_o) || $changed(pin_oe_o) |-> fall_q < FILT + 8;
	endproperty
	a_wr: assert property (p_wr) else $error("port changed off bus");
	property p_ack_on;
		$rose(sda_oe_o) |-> !scl_i && !$past(scl_i);
	endproperty
	a_ack_on: assert property (p_ack_on) else $error("data set in high");
	property p_ack_off;
		$fell(sda_oe_o) |-> !scl_i;
	endproperty
	a_ack_off: assert property (p_ack_off) else $error("data freed in high");
	property p_idle;
		$fell(rst_i) |-> !sda_oe_o [*8];
	endproperty
	a_idle: assert property (p_idle) else $error("bus driven in init");
	c_alert: cover property ($rose(int_n_oe_o));
	c_ack: cover property ($rose(sda_oe_o));
	c_drive: cover property ($changed(pin_oe_o));
endmodule // iox_chk
bind iox_top iox_chk #(.FILT(FILT)) iox_chk_i (.clk_i, .rst_i, .scl_i,
	.sda_i, .sda_o, .sda_oe_o, .pin_i, .pin_o, .pin_oe_o, .pin_pullup_o,
	.addr_strap_bit0_i, .addr_strap_bit1_i, .addr_strap_bit2_i,
	.int_n_o, .int_n_oe_o);

// [tb/iox_host.sv]
// Purpose: bus master model for the expander
// Assumes: released lines rise through the pull-ups
// Notes: quarter bit is four clocks; faster than 400 kHz on purpose
`timescale 1ns/1ps
module iox_host (
	input wire logic clk_i, // System clock, paces the bus
	input wire logic sda_i, // Resolved data wire
	output logic scl_o, // Bus clock, still between frames
	output logic sda_oe_o // Pulls data low when high
);
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// Quarter bit
	task automatic q();
		repeat (4) @(negedge clk_i);
	endtask
	// Start or repeated start, leaves clock low
	task automatic start();
		sda_oe_o = 1'b0;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// Stop, bus left idle
	task automatic stop();
		sda_oe_o = 1'b1;
		q();
		scl_o = 1'b1;
		q();
		sda_oe_o = 1'b0;
		q();
	endtask
	// Data held through the whole high phase
	task automatic bit_x(input logic b, output logic r);
		sda_oe_o = !b;
		q();
		scl_o = 1'b1;
		q();
		r = sda_i;
		q();
		scl_o = 1'b0;
		q();
	endtask
	// Eight bits first bit high, then the ninth
	task automatic byte_x(input logic [7:0] b, input logic nb,
		output logic [7:0] r, output logic n);
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i], r[i]);
		end
		bit_x(nb, n);
	endtask
	// Address, command, one data byte; acks returned
	task automatic wr(input logic [7:0] ad, input logic [7:0] cmd,
		input logic [7:0] d, output logic [7:0] ak);
		logic [7:0] r;
		logic n0, n1, n2;
		start();
		byte_x(ad, 1'b1, r, n0);
		byte_x(cmd, 1'b1, r, n1);
		byte_x(d, 1'b1, r, n2);
		stop();
		ak = {5'h00, !n0, !n1, !n2};
	endtask
	// Command set, repeated start, one byte read then refused
	task automatic rd(input logic [7:0] ad, input logic [7:0] cmd,
		output logic [7:0] d);
		logic [7:0] r;
		logic n;
		start();
		byte_x(ad, 1'b1, r, n);
		byte_x(cmd, 1'b1, r, n);
		start();
		byte_x(ad | 8'h01, 1'b1, r, n);
		byte_x(8'hFF, 1'b1, d, n);
		stop();
	endtask
endmodule // iox_host

// [tb/tb_iox_top.sv]
// Purpose: self-checking bench of the I/O expander
// Assumes: straps at 5, inputs changed only with the bus idle
// Notes: FILT of 1 keeps the bus quick
`timescale 1ns/1ps
`include "iox_consts.svh"
module tb_iox_top;
	import iox_pkg::*;
	localparam logic [7:0] ADW = {`IOX_ADDR_HI, 3'h5, 1'b0};
	logic clk_i = 1'b0;
	logic rst_i, sda_o, sda_oe_o, int_n_o, int_n_oe_o, scl_h, sda_oe_h;
	logic [7:0] ext, pin_o, pin_oe_o, pin_pullup_o, ak, d;
	logic [2:0] strap;
	iox_bus_t bus;
	int err_total = 0;
	int tests_run = 0;
	// Wired-AND data line and pins driven or from outside
	assign bus = {scl_h, !(sda_oe_h || sda_oe_o)};
	wire [7:0] pins = (pin_oe_o & pin_o) | (~pin_oe_o & ext);
	always #12.5 clk_i = !clk_i;
	iox_top #(.FILT(1)) iox_top_i (.clk_i, .rst_i, .scl_i(bus.scl),
		.sda_i(bus.sda), .sda_o, .sda_oe_o, .pin_i(pins), .pin_o,
		.pin_oe_o, .pin_pullup_o, .addr_strap_bit0_i(strap[0]),
		.addr_strap_bit1_i(strap[1]), .addr_strap_bit2_i(strap[2]),
		.int_n_o, .int_n_oe_o);
	iox_host iox_host_i (.clk_i, .sda_i(bus.sda), .scl_o(scl_h),
		.sda_oe_o(sda_oe_h));
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] cmd, input logic [7:0] e);
		iox_host_i.rd(ADW, cmd, d);
		chk("read", e, d);
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic finish_test();
		if (err_total == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Hang guard, well past the expected run
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		finish_test();
	end
	initial begin
		rst_i = 1'b1;
		ext = 8'hC3;
		strap = 3'h5;
		pause(16);
		rst_i = 1'b0;
		pause(12);
		chk("drive", 8'h00, pin_oe_o);
		chk("pullup", 8'hFF, pin_pullup_o);
		rdc(`IOX_CMD_CFG, `IOX_RST_CFG);
		rdc(`IOX_CMD_OUT, `IOX_RST_OUT);
		rdc(`IOX_CMD_POL, `IOX_RST_POL);
		rdc(`IOX_CMD_IN, 8'hC3);
		iox_host_i.wr(ADW, `IOX_CMD_OUT, 8'hA5, ak);
		chk("ack", 8'h07, ak);
		iox_host_i.wr(ADW, `IOX_CMD_CFG, 8'h0F, ak);
		chk("drive", 8'hF0, pin_oe_o);
		chk("latch", 8'hA5, pin_o);
		rdc(`IOX_CMD_CFG, 8'h0F);
		iox_host_i.wr(ADW, `IOX_CMD_POL, 8'h33, ak);
		rdc(`IOX_CMD_IN, 8'h90);
		// Output pins must not alert, input pins must
		ext = 8'h33;
		pause(8);
		chk("alert", 8'h00, {7'h00, int_n_oe_o});
		ext = 8'h31;
		pause(8);
		chk("alert", 8'h01, {7'h00, int_n_oe_o});
		chk("alert lvl", 8'h00, {7'h00, int_n_o});
		rdc(`IOX_CMD_IN, 8'h92);
		pause(8);
		chk("alert", 8'h00, {7'h00, int_n_oe_o});
		// Foreign address and unknown command refused
		iox_host_i.wr(ADW ^ 8'h02, `IOX_CMD_OUT, 8'h00, ak);
		chk("ack", 8'h00, ak);
		iox_host_i.wr(ADW, 8'h04, 8'h00, ak);
		chk("ack", 8'h04, ak);
		chk("latch", 8'hA5, pin_o);
		// Write to the input register is acked but changes nothing
		iox_host_i.wr(ADW, `IOX_CMD_IN, 8'h00, ak);
		chk("ack", 8'h07, ak);
		rdc(`IOX_CMD_IN, 8'h92);
		// Reset in mid-run restores everything
		rst_i = 1'b1;
		pause(4);
		rst_i = 1'b0;
		pause(12);
		chk("drive", 8'h00, pin_oe_o);
		chk("latch", `IOX_RST_OUT, pin_o);
		rdc(`IOX_CMD_POL, `IOX_RST_POL);
		finish_test();
	end
endmodule // tb_iox_top
